// ---- shared/dpps_pkg.sv ----
// Constants and carrier types for the display power sequencing host.
// Assumes a 200 MHz mclk; all timing counts derive from that rate.
// How it works
// - Monitor holds reset low until all ready
// - Reset stays low at least 5 ms
// - Fast-park request high before reset release
// - Keep projector-on until attention low
// - No I2C or DSI before attention low
// - Projector-on high turns chipset on, low off
// - End I2C before dropping projector-on
// - Clock runs 20 ms after projector-on low
// - Reset held high until normal park done
// - Reset asserted only after park; attention released
// - Clock and reset hold 32 us after fast-park
// - Fast-park at least 32 us before supply loss
// - Fast park only when power loss imminent
package dpps_pkg;
   localparam int unsigned CLK_MHZ         = 200;
   localparam int unsigned RESET_HOLD_US   = 5000;
   localparam int unsigned NORMAL_PARK_US  = 20000;
   localparam int unsigned FAST_PARK_US    = 32;
   localparam int unsigned RESET_HOLD_CYC  = RESET_HOLD_US * CLK_MHZ;
   localparam int unsigned NORMAL_PARK_CYC = NORMAL_PARK_US * CLK_MHZ;
   localparam int unsigned FAST_PARK_CYC   = FAST_PARK_US * CLK_MHZ;
   localparam int unsigned CNT_W           = 24;

   typedef enum logic [2:0] {
      DPPS_OFF,
      DPPS_RESET,
      DPPS_INIT,
      DPPS_READY,
      DPPS_NPARK,
      DPPS_FPARK,
      DPPS_FAULT
   } dpps_state_t;

   // Pins driven toward the device
   typedef struct packed {
      logic systemResetLow;
      logic fastParkRequestLow;
      logic projectorOnRequest;
   } dpps_pins_t;

   // Status toward the host user logic
   typedef struct packed {
      logic ready;
      logic busAllowed;
      logic parking;
      logic off;
      logic initFault;
   } dpps_stat_t;
endpackage : dpps_pkg

// ---- rtl/dpps_timer.sv ----
// Down-counting delay timer for the sequencer.
// Assumes load and enable come from mclk logic.
`timescale 1ns/10ps
module dpps_timer
(
   // Clock and reset
   input  wire logic                      mclk,
   input  wire logic                      rst,
   input  wire logic                      clkEn,
   // Control
   input  wire logic                      load,
   input  wire logic [dpps_pkg::CNT_W-1:0] loadValue,
   // Status
   output logic                           expired
);
   import dpps_pkg::*;

   typedef struct packed {
      logic [CNT_W-1:0] count;
   } dpps_tmr_t;

   dpps_tmr_t tmr_q;
   dpps_tmr_t tmr_d;

   always_comb
   begin
      tmr_d = tmr_q;
      if (load)
         tmr_d.count = loadValue;
      else if (tmr_q.count != '0)
         tmr_d.count = tmr_q.count - 24'h000001;
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
         tmr_q <= '0;
      else if (clkEn)
         tmr_q <= tmr_d;
   end

   assign expired = (tmr_q.count == '0) && !load;
endmodule : dpps_timer

// ---- rtl/dpps_host_seq.sv ----
// Host-side power sequencer for the display controller.
// Assumes the device's attention line arrives asynchronously on a pin.
`timescale 1ns/10ps
module dpps_host_seq
#(
   // Delay counts in mclk cycles; defaults are the hardware figures
   parameter int unsigned HOLD_CYC  = dpps_pkg::RESET_HOLD_CYC,
   parameter int unsigned NPARK_CYC = dpps_pkg::NORMAL_PARK_CYC,
   parameter int unsigned FPARK_CYC = dpps_pkg::FAST_PARK_CYC
)
(
   // Clock and reset
   input  wire logic                mclk,
   input  wire logic                rst,
   input  wire logic                clkEn,
   // User requests
   input  wire logic                powerOnReq,
   input  wire logic                powerLossWarn,
   input  wire logic                i2cBusy,
   // Device pins
   input  wire logic                hostAttention,
   output dpps_pkg::dpps_pins_t     pins,
   // Status
   output dpps_pkg::dpps_stat_t     status
);
   import dpps_pkg::*;

   typedef struct packed {
      dpps_state_t  state;
      logic         attnMeta;
      logic         attnSync;
      logic         seenHigh;
      dpps_pins_t   pins;
      dpps_stat_t   stat;
   } dpps_seq_t;

   dpps_seq_t seq_q;
   dpps_seq_t seq_d;

   logic             tmrLoad;
   logic [CNT_W-1:0] tmrValue;
   logic             tmrDone;

   dpps_timer u_timer
   (
      .mclk      (mclk),
      .rst       (rst),
      .clkEn     (clkEn),
      .load      (tmrLoad),
      .loadValue (tmrValue),
      .expired   (tmrDone)
   );

   // ----------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------
   always_comb
   begin
      seq_d          = seq_q;
      tmrLoad        = 1'b0;
      tmrValue       = '0;
      seq_d.attnMeta = hostAttention;
      seq_d.attnSync = seq_q.attnMeta;
      case (seq_q.state)
         DPPS_OFF:
         begin
            seq_d.pins = '{systemResetLow: 1'b0,
                           fastParkRequestLow: 1'b1,
                           projectorOnRequest: 1'b0};
            if (powerOnReq && !powerLossWarn)
            begin
               // Projector-on high, then hold reset low for 5 ms
               seq_d.pins.projectorOnRequest = 1'b1;
               tmrLoad  = 1'b1;
               tmrValue = CNT_W'(HOLD_CYC);
               seq_d.state = DPPS_RESET;
            end
         end
         DPPS_RESET:
         begin
            if (powerLossWarn)
               seq_d.state = DPPS_OFF;
            else if (tmrDone && seq_q.pins.fastParkRequestLow)
            begin
               seq_d.pins.systemResetLow = 1'b1;
               seq_d.seenHigh = 1'b0;
               seq_d.state = DPPS_INIT;
            end
         end
         DPPS_INIT:
         begin
            // Projector-on stays high until attention falls or a power-loss warning arrives
            if (seq_q.attnSync)
               seq_d.seenHigh = 1'b1;
            if (powerLossWarn)
            begin
               seq_d.pins.fastParkRequestLow = 1'b0;
               tmrLoad  = 1'b1;
               tmrValue = CNT_W'(FPARK_CYC);
               seq_d.state = DPPS_FPARK;
            end
            else if (seq_q.seenHigh && !seq_q.attnSync)
            begin
               seq_d.stat.ready      = 1'b1;
               seq_d.stat.busAllowed = 1'b1;
               seq_d.state = DPPS_READY;
            end
         end
         DPPS_READY:
         begin
            if (powerLossWarn)
            begin
               // Warning acts at once, ahead of supply loss
               seq_d.pins.fastParkRequestLow = 1'b0;
               seq_d.stat.busAllowed = 1'b0;
               tmrLoad  = 1'b1;
               tmrValue = CNT_W'(FPARK_CYC);
               seq_d.stat.parking = 1'b1;
               seq_d.state = DPPS_FPARK;
            end
            else if (!powerOnReq)
               seq_d.stat.busAllowed = 1'b0;
            if (!powerOnReq && !powerLossWarn && !i2cBusy)
            begin
               seq_d.pins.projectorOnRequest = 1'b0;
               tmrLoad  = 1'b1;
               tmrValue = CNT_W'(NPARK_CYC);
               seq_d.stat.ready   = 1'b0;
               seq_d.stat.parking = 1'b1;
               seq_d.state = DPPS_NPARK;
            end
         end
         DPPS_NPARK:
         begin
            if (powerLossWarn)
            begin
               seq_d.pins.fastParkRequestLow = 1'b0;
               tmrLoad  = 1'b1;
               tmrValue = CNT_W'(FPARK_CYC);
               seq_d.state = DPPS_FPARK;
            end
            else if (tmrDone)
            begin
               seq_d.pins.systemResetLow = 1'b0;
               seq_d.stat.parking = 1'b0;
               seq_d.stat.off     = 1'b1;
               seq_d.state = DPPS_OFF;
            end
         end
         DPPS_FPARK:
         begin
            seq_d.pins.projectorOnRequest = 1'b0;
            seq_d.stat.ready      = 1'b0;
            seq_d.stat.busAllowed = 1'b0;
            if (tmrDone)
            begin
               seq_d.pins.systemResetLow = 1'b0;
               seq_d.stat.parking = 1'b0;
               seq_d.stat.off     = 1'b1;
               seq_d.state = DPPS_FAULT;
            end
         end
         DPPS_FAULT:
         begin
            // Wait for warning and power-on request to clear before re-arming
            if (!powerLossWarn && !powerOnReq)
               seq_d.state = DPPS_OFF;
         end
         default:
            seq_d.state = DPPS_OFF;
      endcase
      if (seq_d.state == DPPS_RESET || seq_d.state == DPPS_INIT)
         seq_d.stat.off = 1'b0;
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         seq_q       <= '0;
         seq_q.state <= DPPS_OFF;
         seq_q.pins  <= '{systemResetLow: 1'b0,
                          fastParkRequestLow: 1'b1,
                          projectorOnRequest: 1'b0};
         seq_q.stat  <= '{ready: 1'b0, busAllowed: 1'b0, parking: 1'b0,
                          off: 1'b1, initFault: 1'b0};
      end
      else if (clkEn)
         seq_q <= seq_d;
   end

   assign pins   = seq_q.pins;
   assign status = seq_q.stat;

   // ----------------------------------------------------------
   // Checks
   // ----------------------------------------------------------
   release_park_a: assert property (@(posedge mclk) disable iff (rst)
      $rose(pins.systemResetLow) |-> pins.fastParkRequestLow)
      else $error("reset released with fast park low");

   bus_gate_a: assert property (@(posedge mclk) disable iff (rst)
      status.busAllowed |-> !seq_q.attnSync || !seq_q.seenHigh
                            || seq_q.state != DPPS_INIT)
      else $error("bus allowed before init done");

   on_hold_a: assert property (@(posedge mclk) disable iff (rst)
      (seq_q.state == DPPS_INIT) |-> pins.projectorOnRequest)
      else $error("projector-on dropped during init");

   npark_reset_a: assert property (@(posedge mclk) disable iff (rst)
      (seq_q.state == DPPS_NPARK) |-> pins.systemResetLow)
      else $error("reset asserted during normal park");

   fpark_reset_a: assert property (@(posedge mclk) disable iff (rst)
      $fell(pins.fastParkRequestLow) |-> pins.systemResetLow [*8])
      else $error("reset asserted too soon after fast park");

   off_i2c_a: assert property (@(posedge mclk) disable iff (rst)
      $fell(pins.projectorOnRequest) && $past(seq_q.state) == DPPS_READY
      |-> !$past(i2cBusy))
      else $error("projector-on dropped with i2c busy");

   override_a: assert property (@(posedge mclk) disable iff (rst)
      clkEn && seq_q.state == DPPS_NPARK && powerLossWarn
      |=> !pins.fastParkRequestLow)
      else $error("fast park did not override normal park");

   reset_hold_a: assert property (@(posedge mclk) disable iff (rst)
      $rose(pins.projectorOnRequest) |-> !pins.systemResetLow [*8])
      else $error("reset released too early");
endmodule : dpps_host_seq

// ---- tb/dpps_dev_model.sv ----
// Behavioural display controller on the far side of the sequencer.
// Assumes the bench resolves the attention wire with its pull-up.
`timescale 1ns/10ps
module dpps_dev_model
#(
   parameter int LOCK_CYC = 40,
   parameter int LOAD_CYC = 80
)
(
   // Clock
   input  wire logic            mclk,
   // Pins from the sequencer
   input  dpps_pkg::dpps_pins_t pins,
   // Attention line and park state
   output logic                 attnOut,
   output logic                 attnOeLow,
   output logic                 parked
);
   import dpps_pkg::*;
   int initCnt;

   always_ff @(posedge mclk)
   begin
      if (!pins.systemResetLow)
      begin
         initCnt   <= 0;
         attnOeLow <= 1'b1;
         attnOut   <= 1'b0;
      end
      else
      begin
         attnOeLow <= 1'b0;
         if (initCnt < LOCK_CYC + LOAD_CYC)
            initCnt <= initCnt + 1;
         attnOut <= (initCnt < LOCK_CYC + LOAD_CYC);
      end
      parked <= !pins.fastParkRequestLow || !pins.projectorOnRequest;
   end
endmodule : dpps_dev_model

// ---- tb/dpps_host_seq_bench.sv ----
// Self-checking bench for the host power sequencer.
// Assumes the package counts at 200 MHz; run spans under 20 us.
`timescale 1ns/10ps
module dpps_host_seq_bench;
   import dpps_pkg::*;
   // Shortened delays keep the run within a few thousand cycles
   localparam int TB_HOLD  = 300;
   localparam int TB_NPARK = 600;
   localparam int TB_FPARK = 64;
   logic       mclk = 1'b0;
   logic       rst, clkEn, powerOnReq, powerLossWarn, i2cBusy;
   logic       attnOut, attnOeLow, parked;
   wire logic  hostAttention;
   dpps_pins_t pins;
   dpps_stat_t status;
   int         failures = 0;
   int         num_checks = 0;
   int         n;

   // Pull-up wins when the device releases the line
   assign hostAttention = attnOeLow ? 1'b1 : attnOut;

   dpps_host_seq #(.HOLD_CYC(TB_HOLD), .NPARK_CYC(TB_NPARK),
      .FPARK_CYC(TB_FPARK)) dut (.mclk(mclk), .rst(rst), .clkEn(clkEn),
      .powerOnReq(powerOnReq), .powerLossWarn(powerLossWarn),
      .i2cBusy(i2cBusy), .hostAttention(hostAttention),
      .pins(pins), .status(status));

   dpps_dev_model dev (.mclk(mclk), .pins(pins), .attnOut(attnOut),
      .attnOeLow(attnOeLow), .parked(parked));

   initial
   begin
      forever #2.5 mclk = ~mclk;
   end

   task automatic finish_test();
      if (failures == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : finish_test

   task automatic check(input logic ok, input string msg);
      num_checks++;
      if (ok !== 1'b1)
      begin
         failures++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask : check

   task automatic tick(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask : tick

   function automatic logic cond(input int w);
      case (w)
         0: return pins.systemResetLow === 1'b1;
         1: return pins.systemResetLow === 1'b0;
         default: return status.ready === 1'b1;
      endcase
   endfunction : cond

   // Bounded wait; while waiting for ready also watches the host side
   task automatic wait_for(input int w, input int lim, output int cnt);
      cnt = 0;
      while (!cond(w))
      begin
         tick(1);
         cnt++;
         if (w == 2)
            check(pins.projectorOnRequest === 1'b1, "on dropped");
         if (w == 2)
            check(!(status.busAllowed && hostAttention), "bus early");
         if (cnt > lim)
         begin
            check(1'b0, "timeout");
            finish_test();
         end
      end
   endtask : wait_for

   task automatic t_reset();
      check(pins === 3'h2 && status === 5'h02, "reset levels");
   endtask : t_reset

   task automatic t_refuse();
      powerLossWarn = 1'b1;
      powerOnReq    = 1'b1;
      tick(5);
      check(pins.projectorOnRequest === 1'b0, "on taken");
      powerLossWarn = 1'b0;
      powerOnReq    = 1'b0;
      tick(2);
   endtask : t_refuse

   task automatic t_power_up();
      powerOnReq = 1'b1;
      tick(1);
      check(pins.projectorOnRequest === 1'b1, "on late");
      wait_for(0, TB_HOLD + 10, n);
      check(n >= TB_HOLD && n <= TB_HOLD + 2, "hold");
      check(pins.fastParkRequestLow === 1'b1, "park low");
      wait_for(2, 2000, n);
      check(status.busAllowed === 1'b1 && !hostAttention, "no bus");
   endtask : t_power_up

   task automatic t_normal_park();
      i2cBusy    = 1'b1;
      powerOnReq = 1'b0;
      tick(20);
      check(pins.projectorOnRequest === 1'b1, "off early");
      i2cBusy = 1'b0;
      tick(2);
      check(pins.projectorOnRequest === 1'b0, "off late");
      check(status.parking === 1'b1, "no park");
      wait_for(1, TB_NPARK + 10, n);
      check(n >= TB_NPARK - 2, "reset early");
      check(parked === 1'b1, "unparked");
      tick(3);
      check(status.off === 1'b1 && hostAttention, "not off");
   endtask : t_normal_park

   task automatic t_fast_in_normal();
      powerOnReq = 1'b0;
      tick(100);
      powerLossWarn = 1'b1;
      tick(2);
      check(pins.fastParkRequestLow === 1'b0, "no fast");
      wait_for(1, TB_FPARK + 10, n);
      check(n >= TB_FPARK - 2, "fast short");
      check(parked === 1'b1, "unparked");
      powerLossWarn = 1'b0;
      tick(5);
      check(status.off === 1'b1, "not off");
      check(pins.fastParkRequestLow === 1'b1, "fast stuck");
   endtask : t_fast_in_normal

   initial
   begin
      rst           = 1'b1;
      clkEn         = 1'b1;
      powerOnReq    = 1'b0;
      powerLossWarn = 1'b0;
      i2cBusy       = 1'b0;
      tick(2);
      rst = 1'b0;
      tick(1);
      t_reset();
      t_refuse();
      t_power_up();
      t_normal_park();
      t_power_up();
      t_fast_in_normal();
      finish_test();
   end
endmodule : dpps_host_seq_bench
